// ==== include/oag_params.svh ====
// Constants for the operand address generator
`ifndef OAG_PARAMS_SVH
`define OAG_PARAMS_SVH
`define OAG_REDIRECT_NIBBLE 4'hE
`define OAG_PAIR_LSB_MASK   4'hE
`define OAG_RF_ADDR_W       12
`define OAG_PM_ADDR_W       16
`define OAG_RESET_RF_ADDR   12'h000
`define OAG_RESET_PM_ADDR   16'h0000
`define OAG_RESET_BYTE      8'h00
`endif

// ==== include/oag_pkg.sv ====
// Types for the operand address generator
package oag_pkg;
  typedef enum logic [3:0] {
    OAG_WORK_REG     = 4'h0,
    OAG_WORK_PAIR    = 4'h1,
    OAG_REG8         = 4'h2,
    OAG_REG_PAIR8    = 4'h3,
    OAG_IMMEDIATE    = 4'h4,
    OAG_IND_WORK     = 4'h5,
    OAG_IND_WPAIR_RF = 4'h6,
    OAG_IND_WPAIR_PM = 4'h7,
    OAG_IND_REG      = 4'h8,
    OAG_IND_REG_PAIR = 4'h9,
    OAG_INDEXED      = 4'hA,
    OAG_ABS_BRANCH   = 4'hB,
    OAG_REL_BRANCH   = 4'hC,
    OAG_DEC_BRANCH   = 4'hD
  } oag_mode_type;

  typedef enum logic [1:0] {
    OAG_IDLE  = 2'h0,
    OAG_READ1 = 2'h1,
    OAG_READ2 = 2'h3,
    OAG_FIN   = 2'h2
  } oag_fsm_type;

  typedef struct packed {
    oag_fsm_type  state;
    oag_mode_type mode;
    logic [7:0]   wp;
    logic [7:0]   base;
    logic [11:0]  rd_addr;
    logic         rd_req;
    logic [7:0]   hi_byte;
    logic         done;
    logic         rf_valid;
    logic [11:0]  rf_ea;
    logic         pm_valid;
    logic [15:0]  pm_ea;
    logic         imm_valid;
    logic [7:0]   imm;
    logic         pc_load;
    logic [15:0]  pc_value;
  } oag_state_type;
endpackage

// ==== include/oag_cond_if.sv ====
// Interface between address generator and condition evaluator
`timescale 1ns/1ps
interface oag_cond_if;
  logic [3:0] branch_condition_field;
  logic       carry;
  logic       zero;
  logic       sign;
  logic       overflow;
  logic       taken;
  modport gen  (output branch_condition_field, output carry, output zero, output sign, output overflow,
                input taken);
  modport eval (input branch_condition_field, input carry, input zero, input sign, input overflow,
                output taken);
endinterface

// ==== verilog/oag_cond.sv ====
// Branch condition evaluator
`timescale 1ns/1ps
module oag_cond (
  // Condition request and answer
  oag_cond_if.eval cif
);
  logic lt;
  logic base_test;

  assign lt = cif.sign ^ cif.overflow;

  always_comb begin
    base_test = 1'b0;
    case (cif.branch_condition_field[2:0])
      3'h0: base_test = 1'b0;
      3'h1: base_test = lt;
      3'h2: base_test = cif.zero | lt;
      3'h3: base_test = cif.carry | cif.zero;
      3'h4: base_test = cif.overflow;
      3'h5: base_test = cif.sign;
      3'h6: base_test = cif.zero;
      default: base_test = cif.carry;
    endcase
  end

  // Upper half inverts the lower half
  assign cif.taken = base_test ^ cif.branch_condition_field[3];
endmodule

// ==== verilog/oag_top.sv ====
// Operand effective-address generator
// Behaviour
// - Working register n maps to window pointer low, window pointer high, n.
// - Working pair uses even n only, mapped like a working register.
// - Register address outside E0h-EFh gets window pointer low nibble prefixed.
// - E0h-EFh is redirect mode: pointer low, pointer high, low address nibble.
// - Immediate operand is the program byte after the opcode, any 0 to 255.
// - Indirect working register: read byte, prefix window pointer low nibble.
// - Indirect working pair: contents give 12-bit register or 16-bit memory address.
// - Indirect register: read byte at mapped address, prefix pointer low nibble.
// - Indirect register pair supplies a 16-bit program memory address.
// - Indexed: base plus signed working-register offset, prefixed by pointer low nibble.
// - Direct branch loads the 16-bit target into the program counter when its condition test passes.
// - Relative branch adds signed offset to next-instruction address.
// - Four-bit condition field selects one of sixteen flag tests.
`timescale 1ns/1ps
`include "oag_params.svh"
module oag_top (
  // Clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  // Operand request from the sequencer
  input  wire logic                       i_req,
  input  wire oag_pkg::oag_mode_type      i_mode,
  input  wire logic [7:0]                 i_operand,
  input  wire logic [7:0]                 i_aux_byte,
  input  wire logic [15:0]                i_direct_jump_target,
  input  wire logic [7:0]                 i_register_window_pointer,
  input  wire logic [15:0]                i_pc_next,
  input  wire logic [3:0]                 i_branch_condition_field,
  input  wire logic                       i_count_nonzero,
  output logic                            o_ready,
  output logic                            o_done,
  // Flags from the flag register
  input  wire logic                       i_carry,
  input  wire logic                       i_zero,
  input  wire logic                       i_sign,
  input  wire logic                       i_overflow,
  // Register file read port
  output logic                            o_rf_rd_req,
  output logic [`OAG_RF_ADDR_W-1:0]       o_rf_rd_addr,
  input  wire logic                       i_rf_rd_valid,
  input  wire logic [7:0]                 i_rf_rd_data,
  // Resolved operand
  output logic                            o_rf_valid,
  output logic [`OAG_RF_ADDR_W-1:0]       o_rf_ea,
  output logic                            o_pm_valid,
  output logic [`OAG_PM_ADDR_W-1:0]       o_pm_ea,
  output logic                            o_imm_valid,
  output logic [7:0]                      o_immediate_operand,
  // Program counter load
  output logic                            o_pc_load,
  output logic [`OAG_PM_ADDR_W-1:0]       o_pc_value
);
  oag_pkg::oag_state_type cur;
  oag_pkg::oag_state_type next_cur;
  oag_cond_if             cif ();
  logic                   accept;
  logic [7:0]             wp;
  logic [11:0]            map_work;
  logic [11:0]            map_pair;
  logic [11:0]            map_reg8;
  logic [15:0]            rel_target;
  logic [7:0]             index_sum;

  oag_cond u_cond (
    .cif (cif)
  );

  assign cif.branch_condition_field = i_branch_condition_field;
  assign cif.carry                  = i_carry;
  assign cif.zero                   = i_zero;
  assign cif.sign                   = i_sign;
  assign cif.overflow               = i_overflow;

  assign accept = i_req && (cur.state == oag_pkg::OAG_IDLE);
  assign wp     = i_register_window_pointer;

  // Operand to register-file address mapping
  assign map_work = {wp[3:0], wp[7:4], i_operand[3:0]};
  assign map_pair = {wp[3:0], wp[7:4], i_operand[3:0] & `OAG_PAIR_LSB_MASK};
  always_comb begin
    if (i_operand[7:4] == `OAG_REDIRECT_NIBBLE) begin
      map_reg8 = {wp[3:0], wp[7:4], i_operand[3:0]};
    end else begin
      map_reg8 = {wp[3:0], i_operand};
    end
  end

  assign rel_target = i_pc_next + {{8{i_aux_byte[7]}}, i_aux_byte};
  assign index_sum  = cur.base + i_rf_rd_data;

  always_comb begin
    next_cur           = cur;
    next_cur.done      = 1'b0;
    next_cur.rf_valid  = 1'b0;
    next_cur.pm_valid  = 1'b0;
    next_cur.imm_valid = 1'b0;
    next_cur.pc_load   = 1'b0;
    case (cur.state)
      oag_pkg::OAG_IDLE: begin
        if (accept) begin
          next_cur.mode = i_mode;
          next_cur.wp   = wp;
          next_cur.base = i_aux_byte;
          next_cur.done = 1'b1;
          case (i_mode)
            oag_pkg::OAG_WORK_REG: begin
              next_cur.rf_valid = 1'b1;
              next_cur.rf_ea    = map_work;
            end
            oag_pkg::OAG_WORK_PAIR: begin
              next_cur.rf_valid = 1'b1;
              next_cur.rf_ea    = map_pair;
            end
            oag_pkg::OAG_REG8,
            oag_pkg::OAG_REG_PAIR8: begin
              next_cur.rf_valid = 1'b1;
              next_cur.rf_ea    = map_reg8;
            end
            oag_pkg::OAG_IMMEDIATE: begin
              next_cur.imm_valid = 1'b1;
              next_cur.imm       = i_aux_byte;
            end
            oag_pkg::OAG_ABS_BRANCH: begin
              next_cur.pc_load  = cif.taken;
              next_cur.pc_value = i_direct_jump_target;
            end
            oag_pkg::OAG_REL_BRANCH: begin
              next_cur.pc_load  = cif.taken;
              next_cur.pc_value = rel_target;
            end
            oag_pkg::OAG_DEC_BRANCH: begin
              next_cur.pc_load  = i_count_nonzero;
              next_cur.pc_value = rel_target;
            end
            oag_pkg::OAG_IND_WORK,
            oag_pkg::OAG_INDEXED: begin
              next_cur.done    = 1'b0;
              next_cur.state   = oag_pkg::OAG_READ1;
              next_cur.rd_req  = 1'b1;
              next_cur.rd_addr = map_work;
            end
            oag_pkg::OAG_IND_WPAIR_RF,
            oag_pkg::OAG_IND_WPAIR_PM: begin
              next_cur.done    = 1'b0;
              next_cur.state   = oag_pkg::OAG_READ1;
              next_cur.rd_req  = 1'b1;
              next_cur.rd_addr = map_pair;
            end
            oag_pkg::OAG_IND_REG,
            oag_pkg::OAG_IND_REG_PAIR: begin
              next_cur.done    = 1'b0;
              next_cur.state   = oag_pkg::OAG_READ1;
              next_cur.rd_req  = 1'b1;
              next_cur.rd_addr = map_reg8;
            end
            default: begin
              next_cur.done = 1'b1;
            end
          endcase
        end
      end
      oag_pkg::OAG_READ1: begin
        if (i_rf_rd_valid) begin
          case (cur.mode)
            oag_pkg::OAG_IND_WORK,
            oag_pkg::OAG_IND_REG: begin
              next_cur.rd_req   = 1'b0;
              next_cur.state    = oag_pkg::OAG_FIN;
              next_cur.rf_valid = 1'b1;
              next_cur.done     = 1'b1;
              next_cur.rf_ea    = {cur.wp[3:0], i_rf_rd_data};
            end
            oag_pkg::OAG_INDEXED: begin
              next_cur.rd_req   = 1'b0;
              next_cur.state    = oag_pkg::OAG_FIN;
              next_cur.rf_valid = 1'b1;
              next_cur.done     = 1'b1;
              next_cur.rf_ea    = {cur.wp[3:0], index_sum};
            end
            default: begin
              // Pair: high byte at the first address read, low byte at the next
              next_cur.hi_byte = i_rf_rd_data;
              next_cur.rd_addr = cur.rd_addr + 12'h001;
              next_cur.state   = oag_pkg::OAG_READ2;
            end
          endcase
        end
      end
      oag_pkg::OAG_READ2: begin
        if (i_rf_rd_valid) begin
          next_cur.rd_req = 1'b0;
          next_cur.state  = oag_pkg::OAG_FIN;
          next_cur.done   = 1'b1;
          if (cur.mode == oag_pkg::OAG_IND_WPAIR_RF) begin
            next_cur.rf_valid = 1'b1;
            next_cur.rf_ea    = {cur.hi_byte[3:0], i_rf_rd_data};
          end else begin
            next_cur.pm_valid = 1'b1;
            next_cur.pm_ea    = {cur.hi_byte, i_rf_rd_data};
          end
        end
      end
      default: begin
        next_cur.state = oag_pkg::OAG_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur <= '{state: oag_pkg::OAG_IDLE, mode: oag_pkg::OAG_WORK_REG, wp: `OAG_RESET_BYTE,
               base: `OAG_RESET_BYTE, rd_addr: `OAG_RESET_RF_ADDR, rd_req: 1'b0,
               hi_byte: `OAG_RESET_BYTE, done: 1'b0, rf_valid: 1'b0, rf_ea: `OAG_RESET_RF_ADDR,
               pm_valid: 1'b0, pm_ea: `OAG_RESET_PM_ADDR, imm_valid: 1'b0, imm: `OAG_RESET_BYTE,
               pc_load: 1'b0, pc_value: `OAG_RESET_PM_ADDR};
    end else begin
      cur <= next_cur;
    end
  end

  assign o_ready             = (cur.state == oag_pkg::OAG_IDLE);
  assign o_done              = cur.done;
  assign o_rf_rd_req         = cur.rd_req;
  assign o_rf_rd_addr        = cur.rd_addr;
  assign o_rf_valid          = cur.rf_valid;
  assign o_rf_ea             = cur.rf_ea;
  assign o_pm_valid          = cur.pm_valid;
  assign o_pm_ea             = cur.pm_ea;
  assign o_imm_valid         = cur.imm_valid;
  assign o_immediate_operand = cur.imm;
  assign o_pc_load           = cur.pc_load;
  assign o_pc_value          = cur.pc_value;
endmodule

// ==== test/oag_rf_model.sv ====
// Register file model answering read requests
`timescale 1ns/1ps
module oag_rf_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Answer delay select
  input  wire logic        i_slow,
  // Read port
  input  wire logic        i_rd_req,
  input  wire logic [11:0] i_rd_addr,
  output logic             o_rd_valid,
  output logic [7:0]       o_rd_data
);
  logic [1:0] wait_cnt;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt   <= 2'h0;
      o_rd_valid <= 1'b0;
      o_rd_data  <= 8'h5A;
    end else if (o_rd_valid) begin
      o_rd_valid <= 1'b0;
      wait_cnt   <= 2'h0;
      o_rd_data  <= ~o_rd_data;
    end else if (i_rd_req && wait_cnt == (i_slow ? 2'h3 : 2'h0)) begin
      o_rd_valid <= 1'b1;
      o_rd_data  <= i_rd_addr[7:0] ^ 8'hA5;
    end else begin
      wait_cnt  <= wait_cnt + {1'b0, i_rd_req};
      o_rd_data <= ~o_rd_data;
    end
  end
endmodule

// ==== test/oag_props.sv ====
// Checker for the operand address generator
`timescale 1ns/1ps
module oag_props (
  input wire logic                  i_clk,
  input wire logic                  i_rst_n,
  input wire logic                  i_req,
  input wire oag_pkg::oag_mode_type i_mode,
  input wire logic [7:0]            i_operand,
  input wire logic [7:0]            i_aux_byte,
  input wire logic [15:0]           i_direct_jump_target,
  input wire logic [7:0]            i_register_window_pointer,
  input wire logic [15:0]           i_pc_next,
  input wire logic [3:0]            i_branch_condition_field,
  input wire logic                  o_ready,
  input wire logic                  o_done,
  input wire logic                  o_rf_rd_req,
  input wire logic                  o_rf_valid,
  input wire logic [11:0]           o_rf_ea,
  input wire logic                  o_pm_valid,
  input wire logic                  o_imm_valid,
  input wire logic [7:0]            o_immediate_operand,
  input wire logic                  o_pc_load,
  input wire logic [15:0]           o_pc_value
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0]  wp;
  logic [7:0]  op;
  logic [7:0]  aux;
  logic [15:0] pcn;
  logic [15:0] tgt;
  wire tk = i_req && o_ready;
  // Copies of the request fields for the answer cycle
  always_ff @(posedge i_clk) begin
    wp  <= i_register_window_pointer;
    op  <= i_operand;
    aux <= i_aux_byte;
    pcn <= i_pc_next;
    tgt <= i_direct_jump_target;
  end
  a_work_reg_map: assert property (tk && i_mode == oag_pkg::OAG_WORK_REG |=>
    o_done && o_rf_valid && o_rf_ea == {wp[3:0], wp[7:4], op[3:0]}) else $error("work reg address wrong");
  a_work_pair_map: assert property (tk && i_mode == oag_pkg::OAG_WORK_PAIR |=>
    o_rf_valid && o_rf_ea == {wp[3:0], wp[7:4], op[3:1], 1'b0}) else $error("work pair address wrong");
  a_reg_plain_map: assert property (tk && i_mode == oag_pkg::OAG_REG8 && i_operand[7:4] != 4'hE |=>
    o_rf_valid && o_rf_ea == {wp[3:0], op}) else $error("register address wrong");
  a_redirect_map: assert property (tk && i_mode == oag_pkg::OAG_REG8 && i_operand[7:4] == 4'hE |=>
    o_rf_ea == {wp[3:0], wp[7:4], op[3:0]}) else $error("redirect address wrong");
  a_imm_pass: assert property (tk && i_mode == oag_pkg::OAG_IMMEDIATE |=>
    o_imm_valid && o_immediate_operand == aux) else $error("immediate wrong");
  a_abs_target: assert property (tk && i_mode == oag_pkg::OAG_ABS_BRANCH && i_branch_condition_field == 4'h8 |=>
    o_pc_load && o_pc_value == tgt) else $error("direct target wrong");
  a_rel_target: assert property (tk && i_mode == oag_pkg::OAG_REL_BRANCH && i_branch_condition_field == 4'h8 |=>
    o_pc_load && o_pc_value == pcn + {{8{aux[7]}}, aux}) else $error("relative target wrong");
  a_never_taken: assert property (tk && i_mode != oag_pkg::OAG_DEC_BRANCH && i_branch_condition_field == 4'h0 |=>
    !o_pc_load) else $error("false condition loaded");
  a_read_busy: assert property ($rose(o_rf_rd_req) |-> !o_ready ##1 !o_ready) else $error("ready during read");
  c_rel_taken: cover property (o_pc_load && o_done);
  c_pm_done: cover property (o_pm_valid);
  c_ind_done: cover property (o_rf_valid && $fell(o_rf_rd_req));
endmodule
bind oag_top oag_props u_props (.i_clk, .i_rst_n, .i_req, .i_mode, .i_operand, .i_aux_byte, .i_direct_jump_target,
  .i_register_window_pointer, .i_pc_next, .i_branch_condition_field, .o_ready, .o_done, .o_rf_rd_req, .o_rf_valid,
  .o_rf_ea, .o_pm_valid, .o_imm_valid, .o_immediate_operand, .o_pc_load, .o_pc_value);

// ==== test/tb_operand_address_generator.sv ====
// Testbench for the operand address generator
`timescale 1ns/1ps
module tb_operand_address_generator;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_req = 1'b0;
  logic        cnz = 1'b0;
  logic        slow = 1'b0;
  logic [3:0]  cc = 4'h8;
  logic [3:0]  fl = 4'h0;
  logic [7:0]  wp = 8'h00;
  logic [7:0]  opr = 8'h00;
  logic [7:0]  aux = 8'h00;
  logic [15:0] tgt = 16'h0000;
  logic [15:0] pcn = 16'h0000;
  logic        rdv, rdq, rdy, done, rfv, pmv, imv, pcl;
  logic [7:0]  rdd, imm;
  logic [11:0] rda, rfa;
  logic [15:0] pma, pcv;
  int          n_fail = 0;
  int          compares = 0;
  int          cyc = 0;
  oag_pkg::oag_mode_type md = oag_pkg::OAG_WORK_REG;
  oag_top dut_u (.i_clk, .i_rst_n, .i_req, .i_mode(md), .i_operand(opr), .i_aux_byte(aux),
    .i_direct_jump_target(tgt), .i_register_window_pointer(wp), .i_pc_next(pcn), .i_branch_condition_field(cc),
    .i_count_nonzero(cnz), .o_ready(rdy), .o_done(done), .i_carry(fl[3]), .i_zero(fl[2]), .i_sign(fl[1]),
    .i_overflow(fl[0]), .o_rf_rd_req(rdq), .o_rf_rd_addr(rda), .i_rf_rd_valid(rdv), .i_rf_rd_data(rdd),
    .o_rf_valid(rfv), .o_rf_ea(rfa), .o_pm_valid(pmv), .o_pm_ea(pma), .o_imm_valid(imv),
    .o_immediate_operand(imm), .o_pc_load(pcl), .o_pc_value(pcv));
  oag_rf_model rf_u (.i_clk, .i_rst_n, .i_slow(slow), .i_rd_req(rdq), .i_rd_addr(rda), .o_rd_valid(rdv),
    .o_rd_data(rdd));
  always #5 i_clk = ~i_clk;
  task automatic give_verdict();
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] fx(input logic [11:0] a);
    fx = a[7:0] ^ 8'hA5;
  endfunction
  function automatic logic tst(input logic [3:0] c);
    logic x;
    x = fl[1] ^ fl[0];
    case (c[2:0])
      3'h0: tst = 1'b0;
      3'h1: tst = x;
      3'h2: tst = fl[2] | x;
      3'h3: tst = fl[3] | fl[2];
      3'h4: tst = fl[0];
      3'h5: tst = fl[1];
      3'h6: tst = fl[2];
      default: tst = fl[3];
    endcase
    tst = tst ^ c[3];
  endfunction
  // One request, returns in the answer cycle
  task automatic op(input oag_pkg::oag_mode_type m, input logic [7:0] o, input logic [7:0] a);
    int k;
    // Let the previous request strobe settle low for one edge
    @(negedge i_clk);
    while (rdy !== 1'b1) @(negedge i_clk);
    md = m;
    opr = o;
    aux = a;
    i_req = 1'b1;
    @(negedge i_clk);
    i_req = 1'b0;
    for (k = 0; k < 20 && done !== 1'b1; k++) @(negedge i_clk);
    chk(done, 16'h1);
  endtask
  task automatic t_direct();
    logic [7:0] ra [6] = '{8'h00, 8'hDF, 8'hF0, 8'hFF, 8'hE0, 8'hEF};
    wp = 8'h3C;
    for (int n = 0; n < 16; n++) begin
      op(oag_pkg::OAG_WORK_REG, 8'(n), 8'h00);
      chk(rfa, {4'hC, 4'h3, 4'(n)});
    end
    op(oag_pkg::OAG_WORK_PAIR, 8'h07, 8'h00);
    chk(rfa, 12'hC36);
    for (int i = 0; i < 6; i++) begin
      op(oag_pkg::OAG_REG8, ra[i], 8'h00);
      chk(rfa, ra[i][7:4] == 4'hE ? {4'hC, 4'h3, ra[i][3:0]} : {4'hC, ra[i]});
    end
    op(oag_pkg::OAG_REG_PAIR8, 8'hE2, 8'h00);
    chk(rfa, 12'hC32);
    op(oag_pkg::OAG_REG_PAIR8, 8'h20, 8'h00);
    chk(rfa, 12'hC20);
    chk({pmv, rfv}, 16'h1);
    op(oag_pkg::OAG_IMMEDIATE, 8'h00, 8'hFF);
    chk(imm, 16'hFF);
    chk({imv, rfv}, 16'h2);
  endtask
  task automatic t_branch();
    pcn = 16'h1000;
    for (int f = 0; f < 2; f++) begin
      fl = f ? 4'b0101 : 4'b1010;
      for (int n = 0; n < 16; n++) begin
        cc = 4'(n);
        op(oag_pkg::OAG_REL_BRANCH, 8'h00, 8'h80);
        chk(pcl, tst(cc));
        if (tst(cc)) chk(pcv, 16'h0F80);
      end
    end
    cc = 4'h8;
    pcn = 16'hFFFF;
    op(oag_pkg::OAG_REL_BRANCH, 8'h00, 8'h01);
    chk(pcv, 16'h0000);
    tgt = 16'hFFFF;
    op(oag_pkg::OAG_ABS_BRANCH, 8'h00, 8'h00);
    chk(pcv, 16'hFFFF);
    op(oag_pkg::OAG_DEC_BRANCH, 8'h00, 8'hFE);
    chk(pcl, 16'h0);
    cnz = 1'b1;
    op(oag_pkg::OAG_DEC_BRANCH, 8'h00, 8'hFE);
    chk(pcv, 16'hFFFD);
  endtask
  task automatic t_indirect(input logic s);
    logic [7:0] h;
    slow = s;
    wp = 8'h7B;
    h = fx(12'hB72);
    op(oag_pkg::OAG_IND_WORK, 8'h05, 8'h00);
    chk(rfa, {4'hB, fx(12'hB75)});
    chk({pmv, rfv}, 16'h1);
    op(oag_pkg::OAG_IND_REG, 8'h42, 8'h00);
    chk(rfa, {4'hB, fx(12'hB42)});
    chk({pmv, rfv}, 16'h1);
    op(oag_pkg::OAG_IND_REG_PAIR, 8'h44, 8'h00);
    chk(pma, {fx(12'hB44), fx(12'hB45)});
    chk({pmv, rfv}, 16'h2);
    op(oag_pkg::OAG_IND_WPAIR_RF, 8'h03, 8'h00);
    chk(rfa, {h[3:0], fx(12'hB73)});
    chk({pmv, rfv}, 16'h1);
    op(oag_pkg::OAG_IND_WPAIR_PM, 8'h03, 8'h00);
    chk(pma, {h, fx(12'hB73)});
    chk({pmv, rfv}, 16'h2);
    op(oag_pkg::OAG_INDEXED, 8'h05, 8'h40);
    chk(rfa, {4'hB, 8'(8'h40 + fx(12'hB75))});
    chk({pmv, rfv}, 16'h1);
  endtask
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    t_direct();
    t_branch();
    t_indirect(1'b0);
    t_indirect(1'b1);
    give_verdict();
  end
endmodule
